// ---- cmbc_regs.vh ----
// Register map, field positions and buffer word layout of the CAN message buffer control block.
// Included by the block's top-level design file; definitions only.
`ifndef CMBC_REGS_VH
`define CMBC_REGS_VH

`define CMBC_ADDR_W 10
`define CMBC_CTRL_BASE 10'h000
`define CMBC_FULL_LO 10'h004
`define CMBC_FULL_HI 10'h005
`define CMBC_OVF_LO 10'h006
`define CMBC_OVF_HI 10'h007
`define CMBC_RAM_SEL 2'b01
`define CMBC_CTRL_RESET 8'h00

`define CMBC_F_IS_TX 7
`define CMBC_F_ABT 6
`define CMBC_F_LARB 5
`define CMBC_F_ERR 4
`define CMBC_F_REQ 3
`define CMBC_F_RTREN 2
`define CMBC_F_PRI_HI 1
`define CMBC_F_PRI_LO 0

`define CMBC_NUM_TXBUF 8
`define CMBC_NUM_BUF 32
`define CMBC_W_SID 3'h0
`define CMBC_W_EID 3'h1
`define CMBC_W_DLC 3'h2
`define CMBC_W_STAT 3'h7
`define CMBC_MASK_SID 16'h1fff
`define CMBC_MASK_EID 16'h0fff
`define CMBC_MASK_DLC 16'hff1f
`define CMBC_MASK_DATA 16'hffff
`define CMBC_MASK_STAT 16'h1f00
`define CMBC_STAT_FILT_LO 8

`endif

// ---- cmbc_ram.v ----
// Dual-port message buffer RAM; both ports read through a register.
// Assumes one clock; a write and a read of one word in the same cycle on
// different ports return the old word.
`timescale 1ns/1ns
`default_nettype none
module cmbc_ram #(
    parameter AW = 8,
    parameter DW = 16
) (
    input wire clk,
    input wire a_we,
    input wire [AW-1:0] a_addr,
    input wire [DW-1:0] a_wdata,
    output reg [DW-1:0] a_rdata,
    input wire b_we,
    input wire [AW-1:0] b_addr,
    input wire [DW-1:0] b_wdata,
    output reg [DW-1:0] b_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // One process owns the array; on a same-word collision port b wins
    always @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule
`default_nettype wire

// ---- cmbc_top.v ----
// CAN message buffer control: pair control registers, receive full and
// overflow flags, and the 32-buffer message RAM with its word layout.
// Assumes the protocol engine runs on clk and reports events as one-cycle pulses.
// Functional notes
// - Each control word holds two buffers; bit 7 selects transmit (1) or receive.
// - Aborted flag sets when a pending message is aborted, stays 0 on success.
// - Lost-arbitration flag sets when the buffer's message loses arbitration.
// - Transmit-error flag sets on a bus error while the buffer sends.
// - Setting send-request clears aborted, lost-arbitration and error flags.
// - Writing 1 to send-request asks to send; hardware clears it on success.
// - Writing 0 over a set send-request asks to abort that message.
// - Remote frame with auto-reply enabled sets send-request; otherwise untouched.
// - Two-bit priority per buffer, 11 highest down to 00 lowest.
// - Message contents of 32 buffers live in the message RAM.
// - Word 0 holds standard identifier in bits 12-2; bits 15-13 read 0.
// - Word 0 bit 1 is the substitute remote request bit.
// - Word 0 bit 0 selects extended (1) or standard (0) identifier.
// - Word 2 bit 9 is the remote transmission request bit.
// - Word 2 bits 3-0 hold the data length code.
// - Data bytes packed two per word, even byte low, odd byte high.
// - Receive store writes matched filter number to status bits 12-8.
// - Full flag sets on a stored receive; software clears it.
// - Overflow flag sets when a receive targets a full buffer; software clears.
`timescale 1ns/1ns
`default_nettype none
`include "cmbc_regs.vh"
module cmbc_top (
    input wire clk,
    input wire resetn,
    input wire [9:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [15:0] reg_rdata,
    output reg tx_sel_valid,
    output reg [2:0] tx_sel_buf,
    output reg [7:0] abort_pending,
    input wire [2:0] tx_evt_buf,
    input wire tx_done,
    input wire tx_aborted,
    input wire tx_lost_arb,
    input wire tx_error,
    input wire rx_remote,
    input wire [2:0] rx_remote_buf,
    input wire rx_commit,
    input wire [4:0] rx_buf,
    input wire [4:0] rx_filter,
    input wire [7:0] eng_addr,
    input wire eng_we,
    input wire [15:0] eng_wdata,
    output wire [15:0] eng_rdata
);
    reg [7:0] is_tx;
    reg [7:0] abt;
    reg [7:0] larb;
    reg [7:0] err;
    reg [7:0] req;
    reg [7:0] rtren;
    reg [15:0] pri;
    reg [31:0] full;
    reg [31:0] ovf;
    reg [15:0] reg_q;
    reg ram_rd_q;

    reg [7:0] next_req;
    reg [7:0] next_abt;
    reg [7:0] next_larb;
    reg [7:0] next_err;
    reg [7:0] next_abort_pending;
    reg [31:0] next_full;
    reg [31:0] next_ovf;
    reg next_sel_valid;
    reg [2:0] next_sel_buf;
    reg [1:0] best_pri;
    reg [15:0] next_reg_q;

    wire [3:0] ctrl_wr;
    wire ram_hit;
    wire [63:0] ctrl_bytes;
    wire rx_to_tx;
    wire rx_accept;
    wire rx_store;
    wire [15:0] ram_a_rdata;
    wire [15:0] ram_a_wdata;
    wire [7:0] ram_b_addr;
    wire [15:0] ram_b_wdata;

    integer i;
    integer j;
    integer k;

    // Unimplemented bits are dropped on every write path so they read 0
    function [15:0] word_mask;
        input [2:0] w;
        begin
            case (w)
                `CMBC_W_SID: word_mask = `CMBC_MASK_SID;
                `CMBC_W_EID: word_mask = `CMBC_MASK_EID;
                `CMBC_W_DLC: word_mask = `CMBC_MASK_DLC;
                `CMBC_W_STAT: word_mask = `CMBC_MASK_STAT;
                default: word_mask = `CMBC_MASK_DATA;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_wr
            assign ctrl_wr[g] = reg_wr && (reg_addr == `CMBC_CTRL_BASE + g);
        end
        for (g = 0; g < `CMBC_NUM_TXBUF; g = g + 1) begin : g_rd
            assign ctrl_bytes[8*g +: 8] = {is_tx[g], abt[g], larb[g], err[g],
                req[g], rtren[g], pri[2*g +: 2]};
        end
    endgenerate

    assign ram_hit = (reg_addr[9:8] == `CMBC_RAM_SEL);
    assign rx_to_tx = (rx_buf < `CMBC_NUM_TXBUF) && is_tx[rx_buf[2:0]];
    assign rx_accept = rx_commit && !rx_to_tx;
    // A full buffer is not rewritten, so the older message survives the overflow
    assign rx_store = rx_accept && !full[rx_buf];

    // Control state next values, one buffer per loop pass
    always @* begin : ctrl_next
        reg sw;
        reg [7:0] wb;
        reg evt;
        reg sw_set;
        reg sw_clr;
        reg rem_set;
        sw = 1'b0;
        wb = 8'h00;
        evt = 1'b0;
        sw_set = 1'b0;
        sw_clr = 1'b0;
        rem_set = 1'b0;
        next_req = req;
        next_abt = abt;
        next_larb = larb;
        next_err = err;
        next_abort_pending = abort_pending;
        for (i = 0; i < `CMBC_NUM_TXBUF; i = i + 1) begin
            sw = ctrl_wr[i/2];
            wb = reg_wdata[8*(i%2) +: 8];
            evt = (tx_evt_buf == i[2:0]);
            sw_set = sw && wb[`CMBC_F_REQ];
            sw_clr = sw && !wb[`CMBC_F_REQ];
            rem_set = rx_remote && (rx_remote_buf == i[2:0]) && rtren[i] && is_tx[i];
            next_req[i] = sw_set || rem_set ||
                (req[i] && !sw_clr && !(evt && (tx_done || tx_aborted)));
            if (sw_clr && req[i]) begin
                next_abort_pending[i] = 1'b1;
            end else if (sw_set || (evt && (tx_done || tx_aborted))) begin
                next_abort_pending[i] = 1'b0;
            end
            // Flags clear when the request is set, but an event in that cycle wins
            if (sw_set || rem_set) begin
                next_abt[i] = 1'b0;
                next_larb[i] = 1'b0;
                next_err[i] = 1'b0;
            end
            if (evt && tx_aborted) begin
                next_abt[i] = 1'b1;
            end
            if (evt && tx_lost_arb) begin
                next_larb[i] = 1'b1;
            end
            if (evt && tx_error) begin
                next_err[i] = 1'b1;
            end
        end
    end

    // Highest priority value wins; ties go to the higher buffer number
    always @* begin
        next_sel_valid = 1'b0;
        next_sel_buf = 3'h0;
        best_pri = 2'b00;
        // Own loop variable: a shared one would retrigger the other combinational blocks
        for (j = 0; j < `CMBC_NUM_TXBUF; j = j + 1) begin
            if (next_req[j] && is_tx[j] && !next_abort_pending[j] &&
                (!next_sel_valid || pri[2*j +: 2] >= best_pri)) begin
                next_sel_valid = 1'b1;
                next_sel_buf = j[2:0];
                best_pri = pri[2*j +: 2];
            end
        end
    end

    // Software writes 0 to clear a flag; a hardware set in the same cycle wins
    always @* begin
        next_full = full;
        next_ovf = ovf;
        if (reg_wr && reg_addr == `CMBC_FULL_LO) begin
            next_full[15:0] = full[15:0] & reg_wdata;
        end
        if (reg_wr && reg_addr == `CMBC_FULL_HI) begin
            next_full[31:16] = full[31:16] & reg_wdata;
        end
        if (reg_wr && reg_addr == `CMBC_OVF_LO) begin
            next_ovf[15:0] = ovf[15:0] & reg_wdata;
        end
        if (reg_wr && reg_addr == `CMBC_OVF_HI) begin
            next_ovf[31:16] = ovf[31:16] & reg_wdata;
        end
        if (rx_store) begin
            next_full[rx_buf] = 1'b1;
        end
        if (rx_accept && full[rx_buf]) begin
            next_ovf[rx_buf] = 1'b1;
        end
    end

    always @* begin
        next_reg_q = 16'h0000;
        case (reg_addr)
            `CMBC_CTRL_BASE: next_reg_q = ctrl_bytes[15:0];
            `CMBC_CTRL_BASE + 10'h001: next_reg_q = ctrl_bytes[31:16];
            `CMBC_CTRL_BASE + 10'h002: next_reg_q = ctrl_bytes[47:32];
            `CMBC_CTRL_BASE + 10'h003: next_reg_q = ctrl_bytes[63:48];
            `CMBC_FULL_LO: next_reg_q = full[15:0];
            `CMBC_FULL_HI: next_reg_q = full[31:16];
            `CMBC_OVF_LO: next_reg_q = ovf[15:0];
            `CMBC_OVF_HI: next_reg_q = ovf[31:16];
            default: next_reg_q = 16'h0000;
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            is_tx <= 8'h00;
            rtren <= 8'h00;
            pri <= 16'h0000;
            req <= 8'h00;
            abt <= 8'h00;
            larb <= 8'h00;
            err <= 8'h00;
            abort_pending <= 8'h00;
            tx_sel_valid <= 1'b0;
            tx_sel_buf <= 3'h0;
            full <= 32'h00000000;
            ovf <= 32'h00000000;
            reg_q <= 16'h0000;
            ram_rd_q <= 1'b0;
        end else begin
            for (k = 0; k < `CMBC_NUM_TXBUF; k = k + 1) begin
                if (ctrl_wr[k/2]) begin
                    is_tx[k] <= reg_wdata[8*(k%2) + `CMBC_F_IS_TX];
                    rtren[k] <= reg_wdata[8*(k%2) + `CMBC_F_RTREN];
                    pri[2*k +: 2] <= reg_wdata[8*(k%2) +: 2];
                end
            end
            req <= next_req;
            abt <= next_abt;
            larb <= next_larb;
            err <= next_err;
            abort_pending <= next_abort_pending;
            tx_sel_valid <= next_sel_valid;
            tx_sel_buf <= next_sel_buf;
            full <= next_full;
            ovf <= next_ovf;
            reg_q <= reg_rd ? next_reg_q : 16'h0000;
            ram_rd_q <= reg_rd && ram_hit;
        end
    end

    assign reg_rdata = ram_rd_q ? ram_a_rdata : reg_q;

    // Message words never sit in registers of this block
    assign ram_a_wdata = reg_wdata & word_mask(reg_addr[2:0]);
    assign ram_b_addr = rx_store ? {rx_buf, `CMBC_W_STAT} : eng_addr;
    assign ram_b_wdata = rx_store ? {3'b000, rx_filter, 8'h00} :
        (eng_wdata & word_mask(eng_addr[2:0]));

    cmbc_ram #(
        .AW(8),
        .DW(16)
    ) u_ram (
        .clk(clk),
        .a_we(reg_wr && ram_hit),
        .a_addr(reg_addr[7:0]),
        .a_wdata(ram_a_wdata),
        .a_rdata(ram_a_rdata),
        .b_we(rx_store || eng_we),
        .b_addr(ram_b_addr),
        .b_wdata(ram_b_wdata),
        .b_rdata(eng_rdata)
    );
endmodule
`default_nettype wire

// ---- cmbc_engine_model.sv ----
// Behavioural protocol engine standing for the CAN network side.
// Assumes the bench pulses go for one cycle and picks the outcome with mode.
`timescale 1ns/1ns
`default_nettype none
module cmbc_engine_model #(
    parameter int ACK_DLY = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic [1:0] mode,
    input wire logic tx_sel_valid,
    input wire logic [2:0] tx_sel_buf,
    input wire logic [7:0] abort_pending,
    output logic [2:0] tx_evt_buf,
    output logic tx_done,
    output logic tx_aborted,
    output logic tx_lost_arb,
    output logic tx_error
);
    int cnt;
    // Abort acknowledge is slow on purpose so the pending state can be seen
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
            tx_evt_buf <= 3'h0;
            {tx_done, tx_aborted, tx_lost_arb, tx_error} <= 4'h0;
        end else begin
            tx_done <= go && tx_sel_valid && mode == 2'd0;
            tx_lost_arb <= go && tx_sel_valid && mode == 2'd1;
            tx_error <= go && tx_sel_valid && mode == 2'd2;
            tx_aborted <= 1'b0;
            if (go)
                tx_evt_buf <= tx_sel_buf;
            if (abort_pending == 8'h00 || tx_aborted)
                cnt <= 0;
            else
                cnt <= cnt + 1;
            if (cnt == ACK_DLY) begin
                tx_aborted <= 1'b1;
                for (int i = 7; i >= 0; i--)
                    if (abort_pending[i])
                        tx_evt_buf <= i[2:0];
            end
        end
    end
endmodule
`default_nettype wire

// ---- cmbc_checker.sv ----
// Concurrent checks on the message buffer control ports.
// Assumes one clock domain and the register map of the block header.
`timescale 1ns/1ns
`default_nettype none
module cmbc_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [9:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic tx_sel_valid,
    input wire logic [2:0] tx_sel_buf,
    input wire logic [7:0] abort_pending,
    input wire logic [2:0] tx_evt_buf,
    input wire logic tx_done,
    input wire logic tx_aborted,
    input wire logic tx_error,
    input wire logic rx_remote,
    input wire logic rx_commit,
    input wire logic [4:0] rx_buf
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_req0;
        reg_wr && reg_addr == 10'h000 && reg_wdata[7] && reg_wdata[3] && !abort_pending[0];
    endsequence
    // Three quiet cycles: selection is registered up to two cycles after its cause
    sequence s_quiet;
        !reg_wr && !tx_done && !tx_aborted && !rx_remote;
    endsequence
    sequence s_sid_wr;
        reg_wr && reg_addr == 10'h100;
    endsequence
    AST_RD_UNMAP: assert property (reg_rd && reg_addr == 10'h008 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_REQ_SEL: assert property (s_req0 ##1 !(tx_done || tx_aborted || reg_wr) |=> tx_sel_valid)
        else $error("request not selected");
    AST_ABORT_RISE: assert property ($rose(abort_pending[1]) |-> $past(reg_wr && reg_addr == 10'h000 && !reg_wdata[11]))
        else $error("abort without clearing write");
    AST_ABORT_ACK: assert property ($fell(abort_pending[1]) |-> $past(((tx_aborted || tx_done) && tx_evt_buf == 3'd1) || (reg_wr && reg_addr == 10'h000 && reg_wdata[11])))
        else $error("abort dropped without engine ack");
    AST_SEL_HOLD: assert property (s_quiet [*3] |-> $stable(tx_sel_buf) && $stable(tx_sel_valid))
        else $error("selection moved without cause");
    AST_FULL_SET: assert property (rx_commit && rx_buf == 5'd16 ##1 !reg_wr ##1 reg_rd && reg_addr == 10'h005 |=> reg_rdata[0])
        else $error("full flag not set");
    AST_ERR_FLAG: assert property (tx_error && tx_evt_buf == 3'd0 ##1 reg_rd && reg_addr == 10'h000 |=> reg_rdata[4])
        else $error("error flag not set");
    AST_SID_MASK: assert property (s_sid_wr ##[1:2] reg_rd && reg_addr == 10'h100 |=> reg_rdata[15:13] == 3'b000)
        else $error("identifier word upper bits not zero");
endmodule
bind cmbc_top cmbc_checker i_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_sel_valid(tx_sel_valid), .tx_sel_buf(tx_sel_buf),
    .abort_pending(abort_pending), .tx_evt_buf(tx_evt_buf), .tx_done(tx_done), .tx_aborted(tx_aborted),
    .tx_error(tx_error), .rx_remote(rx_remote), .rx_commit(rx_commit), .rx_buf(rx_buf));
`default_nettype wire

// ---- can_message_buffer_control_test.sv ----
// Self-checking bench for the message buffer control block.
// Assumes the engine model beside it and a 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module can_message_buffer_control_test;
    logic clk, resetn, reg_wr, reg_rd, go, rx_remote, rx_commit, eng_we;
    logic tx_sel_valid, tx_done, tx_aborted, tx_lost_arb, tx_error;
    logic [9:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, eng_wdata, eng_rdata;
    logic [7:0] abort_pending, eng_addr;
    logic [2:0] tx_sel_buf, tx_evt_buf, rx_remote_buf;
    logic [4:0] rx_buf, rx_filter;
    logic [1:0] mode;
    int err_count, n_checks;
    cmbc_top i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_sel_valid(tx_sel_valid), .tx_sel_buf(tx_sel_buf),
        .abort_pending(abort_pending), .tx_evt_buf(tx_evt_buf), .tx_done(tx_done), .tx_aborted(tx_aborted),
        .tx_lost_arb(tx_lost_arb), .tx_error(tx_error), .rx_remote(rx_remote), .rx_remote_buf(rx_remote_buf),
        .rx_commit(rx_commit), .rx_buf(rx_buf), .rx_filter(rx_filter), .eng_addr(eng_addr), .eng_we(eng_we),
        .eng_wdata(eng_wdata), .eng_rdata(eng_rdata));
    cmbc_engine_model i_eng (.clk(clk), .resetn(resetn), .go(go), .mode(mode), .tx_sel_valid(tx_sel_valid),
        .tx_sel_buf(tx_sel_buf), .abort_pending(abort_pending), .tx_evt_buf(tx_evt_buf), .tx_done(tx_done),
        .tx_aborted(tx_aborted), .tx_lost_arb(tx_lost_arb), .tx_error(tx_error));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [9:0] a, logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [9:0] a, logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 cmp($sformatf("register %h", a), exp, reg_rdata);
    endtask
    task automatic ev(logic [1:0] m);
        @(posedge clk);
        go <= 1'b1;
        mode <= m;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic remote(logic [2:0] b);
        @(posedge clk);
        rx_remote <= 1'b1;
        rx_remote_buf <= b;
        @(posedge clk);
        rx_remote <= 1'b0;
    endtask
    task automatic commit(logic [4:0] b, logic [4:0] f);
        @(posedge clk);
        rx_commit <= 1'b1;
        rx_buf <= b;
        rx_filter <= f;
        @(posedge clk);
        rx_commit <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Whole run is about a hundred cycles; the limit of 5000 cycles leaves wide margin
    initial begin
        #20000;
        err_count++;
        $display("[FAIL] watchdog expected end seen hang");
        print_verdict;
    end
    initial begin
        {reg_wr, reg_rd, go, rx_remote, rx_commit, eng_we} = 6'h00;
        {reg_addr, reg_wdata, eng_wdata, eng_addr} = '0;
        {mode, rx_remote_buf, rx_buf, rx_filter} = '0;
        resetn = 1'b0;
        err_count = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        for (int a = 0; a < 9; a++)
            rd(a[9:0], 16'h0000);
        $display("Test reset values done");
        wr(10'h000, 16'h898b);
        rd(10'h000, 16'h898b);
        cmp("selection", 16'h0008, {12'h0, tx_sel_valid, tx_sel_buf});
        ev(2'd1);
        rd(10'h000, 16'h89ab);
        ev(2'd2);
        rd(10'h000, 16'h89bb);
        wr(10'h000, 16'h898b);
        rd(10'h000, 16'h898b);
        ev(2'd0);
        rd(10'h000, 16'h8983);
        cmp("selection", 16'h0009, {12'h0, tx_sel_valid, tx_sel_buf});
        $display("Test transmit flags done");
        wr(10'h000, 16'h8183);
        @(posedge clk);
        #1 cmp("abort pending", 16'h0002, {8'h00, abort_pending});
        repeat (8) @(posedge clk);
        rd(10'h000, 16'hc183);
        cmp("abort pending", 16'h0000, {8'h00, abort_pending});
        cmp("selection valid", 16'h0000, {15'h0, tx_sel_valid});
        $display("Test abort done");
        wr(10'h000, 16'h8087);
        remote(3'd0);
        remote(3'd1);
        rd(10'h000, 16'hc08f);
        $display("Test remote reply done");
        // Higher buffer now has the higher priority, so it must win over buffer 0
        wr(10'h000, 16'h8b88);
        rd(10'h000, 16'h8b88);
        cmp("selection", 16'h0009, {12'h0, tx_sel_valid, tx_sel_buf});
        $display("Test priority done");
        commit(5'd16, 5'h15);
        rd(10'h005, 16'h0001);
        rd(10'h187, 16'h1500);
        commit(5'd16, 5'h03);
        rd(10'h007, 16'h0001);
        rd(10'h187, 16'h1500);
        wr(10'h005, 16'hfffe);
        rd(10'h005, 16'h0000);
        commit(5'd0, 5'h01);
        rd(10'h004, 16'h0000);
        $display("Test receive done");
        wr(10'h100, 16'hffff);
        rd(10'h100, 16'h1fff);
        wr(10'h101, 16'hffff);
        rd(10'h101, 16'h0fff);
        wr(10'h102, 16'hfeef);
        rd(10'h102, 16'hfe0f);
        @(posedge clk);
        eng_we <= 1'b1;
        eng_addr <= 8'h03;
        eng_wdata <= 16'hb2a1;
        @(posedge clk);
        eng_we <= 1'b0;
        eng_addr <= 8'h00;
        rd(10'h103, 16'hb2a1);
        cmp("engine read", 16'h1fff, eng_rdata);
        $display("Test buffer layout done");
        print_verdict;
    end
endmodule
`default_nettype wire
